//--- hdl/asrc_delay.sv
`timescale 1ns/100ps
`default_nettype none
// down counter: load a count, done when it reaches zero
module asrc_delay #(
  parameter int W = 24
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] count;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0) && !load;
endmodule
`default_nettype wire

//--- hdl/asrc_host.sv
`timescale 1ns/100ps
`default_nettype none
// host controller for a 64K x 16 asynchronous static memory
module asrc_host
  import asrc_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire asrc_pkg::asrc_req_t       req,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  output logic [asrc_pkg::DATA_W-1:0]    rdata,
  output logic                           rdata_valid,
  output logic                           write_done,
  output asrc_pkg::asrc_pins_t           pins,
  input  wire logic [asrc_pkg::DATA_W-1:0] mem_data_in,
  output logic [asrc_pkg::DATA_W-1:0]    mem_data_out,
  output logic                           mem_data_oe
);
  import asrc_pkg::*;

  typedef enum logic [2:0] {
    ST_POWER, ST_IDLE, ST_READ, ST_TURN, ST_WSETUP, ST_WPULSE, ST_WEND
  } asrc_state_t;

  asrc_state_t       state;
  asrc_state_t       next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic              pwr_load;
  logic              pwr_done;
  logic              pwr_armed;
  asrc_req_t         cur;

  // power-up wait runs in a long counter so a bench can shrink it
  assign pwr_load = rst_n && !pwr_armed;
  asrc_delay #(.W(24)) u_power (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (pwr_load),
    .value    (24'(POWER_UP_CYCLES)),
    .done     (pwr_done)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwr_armed <= 1'b0;
    end else begin
      pwr_armed <= 1'b1;
    end
  end

  // handshake: accept only in idle, after power-up
  assign req_ready = (state == ST_IDLE);
  wire take     = req_ready && req_valid;
  wire cnt_zero = (cnt == '0);

  // next-state decode
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (!cnt_zero) begin
      next_cnt = cnt - 1'b1;
    end
    case (state)
      ST_POWER: begin
        if (pwr_armed && pwr_done) begin // [R01]
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take && req.write) begin
          next_state = ST_WSETUP;
          next_cnt   = '0;
        end else if (take) begin
          next_state = ST_READ; // [R06]
          next_cnt   = CNT_W'(READ_CYC - 1);
        end
      end
      ST_READ: begin
        if (cnt_zero) begin
          next_state = ST_TURN; // [R17]
          next_cnt   = CNT_W'(TURN_CYC - 1);
        end
      end
      ST_TURN: begin
        if (cnt_zero) begin
          next_state = ST_IDLE;
        end
      end
      ST_WSETUP: begin
        next_state = ST_WPULSE; // [R11]
        next_cnt   = CNT_W'(WPULSE_CYC - 1);
      end
      ST_WPULSE: begin
        if (cnt_zero) begin
          next_state = ST_WEND; // [R10]
        end
      end
      ST_WEND: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_POWER;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_POWER;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // latch the request; address and data held steady for the whole cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (take) begin
      cur <= req; // [R11] [R12]
    end
  end

  // pin drive, all from flops so edges land on clock boundaries
  wire reading = (next_state == ST_READ);
  wire writing = (next_state == ST_WSETUP) || (next_state == ST_WPULSE) ||
                 (next_state == ST_WEND);
  wire we_low  = (next_state == ST_WPULSE);
  wire asrc_req_t nreq = take ? req : cur;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pins         <= PINS_IDLE; // [R02]
      mem_data_oe  <= 1'b0;
      mem_data_out <= '0;
    end else begin
      // select and lanes open with the address, before write enable falls
      pins.chip_select_n      <= !(reading || writing); // [R13] [R16]
      pins.output_enable_n    <= !reading; // [R03] [R08]
      pins.write_enable_n     <= !we_low; // [R04] [R16]
      pins.lane_low_enable_n  <= !((reading || writing) && nreq.lanes[0]); // [R13]
      pins.lane_high_enable_n <= !((reading || writing) && nreq.lanes[1]);
      if (reading || writing) begin
        pins.addr <= nreq.addr;
      end
      // data driven only in write states, never after a read until turnaround
      mem_data_oe  <= writing; // [R12] [R17] [R14]
      mem_data_out <= nreq.wdata;
    end
  end

  // read sample at the end of the access window; write completion pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata       <= '0;
      rdata_valid <= 1'b0;
      write_done  <= 1'b0;
    end else begin
      rdata_valid <= (state == ST_READ) && cnt_zero; // [R06]
      write_done  <= (state == ST_WEND);
      if ((state == ST_READ) && cnt_zero) begin
        rdata <= mem_data_in & {{8{cur.lanes[1]}}, {8{cur.lanes[0]}}}; // [R05]
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/asrc_pkg.sv
// Behaviour
// R01: wait at least 100 us after power-up before the first memory access.
// R02: chip_select high floats all data pins; device enters standby within 10 ns.
// R03: select, output enable low, write enable high: enabled lanes drive read data.
// R04: select and write enable low: output enable ignored, enabled lanes written.
// R05: selected with outputs or both lanes disabled: data pins float.
// R06: read cycle at least 10 ns; data valid within 10 ns of stable address.
// R07: previous read data held at least 3 ns after an address change.
// R08: read data valid within 5 ns of output or lane enable falling.
// R09: data outputs float within 5 ns after output, chip or lane disable.
// R10: write cycle at least 10 ns with write enable low at least 7 ns.
// R11: address stable from write start, 8 ns before write end, zero hold.
// R12: write data valid 5 ns before write end, removable at write end.
// R13: chip_select low 8 ns and lane enable 7 ns before write end.
// R14: device releases data within 5 ns of write enable low, drives 3 ns after rise.
// R15: chip_select and write enable rising together keep data outputs floating.
// R16: chip_select read: address valid by select fall, write enable high throughout.
// R17: round minimum intervals up to clock cycles; never fight the memory on data.
package asrc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 16;
  localparam int LANE_W        = 2;
  // times as printed, in their own units
  localparam int POWER_UP_US            = 100;
  localparam int READ_CYCLE_MIN_NS      = 10;
  localparam int ADDRESS_ACCESS_MAX_NS  = 10;
  localparam int OE_ACCESS_MAX_NS       = 5;
  localparam int FLOAT_MAX_NS           = 5;
  localparam int WRITE_CYCLE_MIN_NS     = 10;
  localparam int WRITE_PULSE_MIN_NS     = 7;
  localparam int ADDR_SETUP_WRITE_END_NS = 8;
  localparam int DATA_SETUP_WRITE_END_NS = 5;
  localparam int LANE_SETUP_WRITE_END_NS = 7;
  localparam int WE_LOW_Z_MIN_NS        = 3;
  // cycle counts, least times rounded up, at least one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int POWER_UP_CYC = (POWER_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // sample point: access plus one cycle of board and sampling margin
  localparam int READ_CYC   = cyc_up(ADDRESS_ACCESS_MAX_NS) + 1;
  localparam int WPULSE_CYC = cyc_up(WRITE_PULSE_MIN_NS > ADDR_SETUP_WRITE_END_NS ?
                                     WRITE_PULSE_MIN_NS : ADDR_SETUP_WRITE_END_NS);
  localparam int WCYCLE_CYC = cyc_up(WRITE_CYCLE_MIN_NS);
  // idle cycles after a read before the host may drive data again
  localparam int TURN_CYC   = cyc_up(FLOAT_MAX_NS);
  localparam int CNT_W      = 4;

  typedef struct packed {
    logic              write;
    logic [LANE_W-1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic              chip_select_n;
    logic              output_enable_n;
    logic              write_enable_n;
    logic              lane_low_enable_n;
    logic              lane_high_enable_n;
    logic [ADDR_W-1:0] addr;
  } asrc_pins_t;

  localparam asrc_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
endpackage

//--- verif/asrc_host_properties.sv
`timescale 1ns/100ps
`default_nettype none
module asrc_host_properties
  import asrc_pkg::*;
#(
  parameter int POWER_UP_CYCLES = 4
) (
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  input wire asrc_pkg::asrc_req_t       req,
  input wire logic                      req_valid,
  input wire logic                      req_ready,
  input wire logic [asrc_pkg::DATA_W-1:0] rdata,
  input wire logic                      rdata_valid,
  input wire logic                      write_done,
  input wire asrc_pkg::asrc_pins_t      pins,
  input wire logic [asrc_pkg::DATA_W-1:0] mem_data_in,
  input wire logic [asrc_pkg::DATA_W-1:0] mem_data_out,
  input wire logic                      mem_data_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic cs = pins.chip_select_n;
  wire logic oe = pins.output_enable_n;
  wire logic we = pins.write_enable_n;
  logic [15:0] up_cnt;
  // counter, since a repetition cannot span the full power-up wait
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      up_cnt <= 16'h0000;
    else if (up_cnt < POWER_UP_CYCLES)
      up_cnt <= up_cnt + 16'h0001;
  end
  a_power_up_idle: assert property (up_cnt < POWER_UP_CYCLES |-> cs && !req_ready)
    else $error("access before power-up wait");
  a_write_pulse: assert property ($fell(we) |=> $rose(we) ##1 !$fell(we) [*2])
    else $error("write pulse or cycle wrong");
  a_addr_hold: assert property (!we |-> $stable(pins.addr) ##1 $stable(pins.addr))
    else $error("address moved around write");
  a_data_setup: assert property (!we |-> mem_data_oe && $stable(mem_data_out) ##1 mem_data_oe)
    else $error("write data not held");
  a_lane_setup: assert property ($fell(we) |-> !cs && $past(!cs) &&
    !(pins.lane_low_enable_n && pins.lane_high_enable_n) &&
    $stable({pins.lane_low_enable_n, pins.lane_high_enable_n}))
    else $error("select or lanes late for write");
  a_read_we_high: assert property (!oe |-> we && !cs ##1 (oe || $stable(pins.addr)))
    else $error("read controls wrong");
  a_no_fight: assert property (mem_data_oe |-> oe && $past(oe))
    else $error("host drives during read");
  a_read_answer: assert property ($fell(oe) |-> ##2 rdata_valid && $rose(oe))
    else $error("read answer timing wrong");
  c_read: cover property (rdata_valid);
  c_write: cover property (write_done);
  c_write_read: cover property ($fell(we) ##[1:8] $fell(oe));
endmodule
bind asrc_host asrc_host_properties #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_props (
  .core_clk     (core_clk),
  .rst_n        (rst_n),
  .req          (req),
  .req_valid    (req_valid),
  .req_ready    (req_ready),
  .rdata        (rdata),
  .rdata_valid  (rdata_valid),
  .write_done   (write_done),
  .pins         (pins),
  .mem_data_in  (mem_data_in),
  .mem_data_out (mem_data_out),
  .mem_data_oe  (mem_data_oe)
);
`default_nettype wire

//--- verif/asrc_sram_model.sv
`timescale 1ns/100ps
`default_nettype none
module asrc_sram_model
  import asrc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire asrc_pkg::asrc_pins_t pins,
  input  wire logic [15:0]          host_data,
  input  wire logic                 host_oe,
  output logic [15:0]               bus
);
  logic [15:0] mem [0:65535];
  logic [15:0] junk = 16'ha5a5;
  wire logic       sel = !pins.chip_select_n;
  wire logic       we  = pins.write_enable_n;
  wire logic [1:0] ln  = ~{pins.lane_high_enable_n, pins.lane_low_enable_n};
  wire logic       rd  = sel && !pins.output_enable_n && we;
  wire logic [15:0] drv = {{8{rd && ln[1]}}, {8{rd && ln[0]}}};
  // no pull on the bus: released bits toggle so a stale read cannot pass
  always @(posedge core_clk) junk <= ~junk;
  always_comb bus = host_oe ? host_data : (mem[pins.addr] & drv) | (junk & ~drv);
  // byte lanes land when write enable rises
  always @(posedge we) begin
    if (sel && ln[0]) mem[pins.addr][7:0] <= host_data[7:0];
    if (sel && ln[1]) mem[pins.addr][15:8] <= host_data[15:8];
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import asrc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  asrc_req_t req = '0;
  logic req_valid = 1'b0;
  logic req_ready, rdata_valid, write_done, mem_data_oe;
  logic [15:0] rdata, mem_data_in, mem_data_out;
  asrc_pins_t pins;
  int err_total = 0;
  int check_count = 0;
  // write, lanes, addr, wdata, expected read data
  logic [50:0] rows [8] = '{
    {1'b1, 2'h3, 16'h0001, 16'h1234, 16'h0000}, {1'b1, 2'h3, 16'hffff, 16'habcd, 16'h0000},
    {1'b0, 2'h3, 16'h0001, 16'h0000, 16'h1234}, {1'b0, 2'h1, 16'hffff, 16'h0000, 16'h00cd},
    {1'b1, 2'h2, 16'h0001, 16'h55aa, 16'h0000}, {1'b0, 2'h3, 16'h0001, 16'h0000, 16'h5534},
    {1'b0, 2'h2, 16'hffff, 16'h0000, 16'hab00}, {1'b1, 2'h1, 16'h0000, 16'h0077, 16'h0000}};
  always #5 core_clk = ~core_clk;
  asrc_host #(.POWER_UP_CYCLES(4)) uut (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .write_done(write_done), .pins(pins), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
  asrc_sram_model mem_i (.core_clk(core_clk), .pins(pins), .host_data(mem_data_out),
    .host_oe(mem_data_oe), .bus(mem_data_in));
  task automatic results;
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // release reset and check for four cycles that ready stays low and select stays high
  task automatic pwr;
    rst_n = 1'b1;
    repeat (4) begin
      @(negedge core_clk);
      chk(req_ready === 1'b0 && pins.chip_select_n === 1'b1, "ready in power-up");
    end
  endtask
  task automatic run(input logic [50:0] r);
    int k;
    req = r[50:16];
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    chk(k < 50, "never ready");
    if (k >= 50) results();
    @(negedge core_clk);
    req_valid = 1'b0;
    k = 1;
    while (k < 9 && (r[50] ? write_done : rdata_valid) !== 1'b1) begin
      @(negedge core_clk);
      k++;
    end
    chk(k == (r[50] ? 4 : 3), "answer late or missing");
    if (!r[50]) chk(rdata === r[15:0], "read data wrong");
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    chk(pins === PINS_IDLE && mem_data_oe === 1'b0, "pins not idle in reset");
    pwr();
    foreach (rows[i]) run(rows[i]);
    // reset lands after select opens, before write enable falls: the write must not land
    req = rows[0][50:16];
    req_valid = 1'b1;
    @(negedge core_clk);
    rst_n = 1'b0;
    req_valid = 1'b0;
    @(negedge core_clk);
    chk(pins === PINS_IDLE && mem_data_oe === 1'b0, "reset left pins");
    pwr();
    run(rows[5]);
    results();
  end
endmodule
`default_nettype wire
